// ==== logic/bsio_unit.sv ====
// Bit-serial I/O unit engine with its receive-word FIFO
// Behaviour
// - Input bits and output bits live in their own bit-addressed space of 32768 each, reached in fields of 1 to 16 bits.
// - Every transfer drives its bit address on fifteen address lines, 0 to 32767.
// - The base bit address is the workspace register value shifted right by one, its lowest bit dropped.
// - Single-bit operations add the displacement to the base; field operations use the base alone.
// - The field output operation shifts a 1 to 16 bit pattern out on the serial out pin, stepping the address after each bit.
// - The test operation samples the serial in pin at the addressed bit into the equal flag.
// - A field operation takes its storage word from the first operand and its bit count from the second.
// - Lengths 1 to 8 use only the most significant byte, starting from its least significant bit.
// - Received bits fill the field from its least significant position upward.
// - The bit address increments for each new bit until the count is done.
// - Field input clears unused bits of the byte or word and leaves the other byte untouched on byte transfers.
// - Adding hexadecimal 20 to the register value moves to the next block of sixteen bits.
// - Bit transfers never make memory read or write cycles.
// - Set-to-zero drives a zero and set-to-one a one on the serial out pin at the addressed bit.
// - The single-bit displacement is a signed eight-bit value from -128 to +127.
`timescale 1ns/100ps
`default_nettype none

module bsio_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int PTR_W = 4
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PTR_W-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [PTR_W:0] count_q, count_d;
  logic notFull_q, notFull_d, notEmpty_q, notEmpty_d;
  logic [WIDTH-1:0] head_q, head_d;
  logic doPush, doPop;

  assign inReady = notFull_q;
  assign outValid = notEmpty_q;
  assign outData = head_q;
  assign doPush = inValid && notFull_q;
  assign doPop = outReady && notEmpty_q;

  always_comb
  begin
    mem_d = mem_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (doPush)
    begin
      mem_d[wrPtr_q] = inData;
      wrPtr_d = wrPtr_q + 1'b1;
    end
    if (doPop)
    begin
      rdPtr_d = rdPtr_q + 1'b1;
    end
    if (doPush && !doPop)
    begin
      count_d = count_q + 1'b1;
    end
    else if (doPop && !doPush)
    begin
      count_d = count_q - 1'b1;
    end
    notFull_d = (count_d != (PTR_W+1)'(DEPTH));
    notEmpty_d = (count_d != '0);
    // Head word kept in its own flop so the output is not a read mux
    head_d = mem_d[rdPtr_d];
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= '0;
      end
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      notFull_q <= 1'b1;
      notEmpty_q <= 1'b0;
      head_q <= '0;
    end
    else
    begin
      mem_q <= mem_d;
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
      notFull_q <= notFull_d;
      notEmpty_q <= notEmpty_d;
      head_q <= head_d;
    end
  end
endmodule // bsio_fifo

module bsio_unit (
  input wire logic clock,
  input wire logic nrst,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [2:0] cmdOp,
  input wire logic [15:0] cmdBase,
  input wire logic [7:0] cmdDisp,
  input wire logic [3:0] cmdCount,
  input wire logic [15:0] cmdWord,
  output logic [14:0] bitAddr,
  output logic bitStrobe,
  output logic serialOutPin,
  input wire logic serialInPin,
  output logic equalStatusFlag,
  output logic testDone,
  output logic wordValid,
  input wire logic wordReady,
  output logic [15:0] wordOut
);
  bsio_pkg::bsio_state_e state_q, state_d;
  bsio_pkg::bsio_op_e op_q, op_d;
  logic [bsio_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [bsio_pkg::WORD_W-1:0] src_q, src_d;
  logic [bsio_pkg::WORD_W-1:0] acc_q, acc_d;
  logic [bsio_pkg::CNT_W-1:0] len_q, len_d;
  logic [bsio_pkg::CNT_W-1:0] idx_q, idx_d;
  logic byteMode_q, byteMode_d;
  logic [2:0] wait_q, wait_d;
  logic idle_q, idle_d;
  logic strobe_q, strobe_d;
  logic out_q, out_d;
  logic eq_q, eq_d;
  logic testDone_q, testDone_d;
  logic syncA_q, syncB_q;
  logic [bsio_pkg::ADDR_W-1:0] baseAddr;
  logic [bsio_pkg::ADDR_W-1:0] dispExt;
  logic [bsio_pkg::CNT_W-1:0] cmdLen;
  logic [4:0] bitPos;
  logic [bsio_pkg::WORD_W-1:0] resultWord;
  logic pushReady;

  // Register bit 0 is dropped, so one step of the register value is half a bit
  assign baseAddr = cmdBase[bsio_pkg::WORD_W-1:bsio_pkg::BASE_LSB];
  assign dispExt = {{(bsio_pkg::ADDR_W-8){cmdDisp[7]}}, cmdDisp};
  // A count of zero encodes a full sixteen-bit field
  assign cmdLen = (cmdCount == 4'h0) ? bsio_pkg::FULL_WORD_LEN : {1'b0, cmdCount};
  assign bitPos = byteMode_q ? (idx_q + 5'(bsio_pkg::HIGH_BYTE_LSB)) : idx_q;
  assign resultWord = byteMode_q ? {acc_q[15:8], src_q[7:0]} : acc_q;

  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    addr_d = addr_q;
    src_d = src_q;
    acc_d = acc_q;
    len_d = len_q;
    idx_d = idx_q;
    byteMode_d = byteMode_q;
    wait_d = wait_q;
    strobe_d = 1'b0;
    out_d = out_q;
    eq_d = eq_q;
    testDone_d = 1'b0;
    case (state_q)
      bsio_pkg::ST_IDLE:
      begin
        if (cmdValid)
        begin
          op_d = bsio_pkg::bsio_op_e'(cmdOp);
          src_d = cmdWord;
          acc_d = bsio_pkg::WORD_RESET;
          idx_d = '0;
          if (cmdOp == bsio_pkg::LOAD_SERIAL_FIELD_OP || cmdOp == bsio_pkg::STORE_SERIAL_FIELD_OP)
          begin
            addr_d = baseAddr;
            len_d = cmdLen;
            byteMode_d = (cmdLen <= 5'(bsio_pkg::BYTE_LEN_MAX));
          end
          else
          begin
            addr_d = baseAddr + dispExt;
            len_d = 5'h01;
            byteMode_d = 1'b0;
          end
          state_d = bsio_pkg::ST_SETUP;
        end
      end
      bsio_pkg::ST_SETUP:
      begin
        // Data is launched one cycle after the address, the strobe follows after settling
        if (op_q == bsio_pkg::LOAD_SERIAL_FIELD_OP)
        begin
          out_d = src_q[bitPos[3:0]];
        end
        else if (op_q == bsio_pkg::SET_BIT_ONE_OP)
        begin
          out_d = 1'b1;
        end
        else if (op_q == bsio_pkg::SET_BIT_ZERO_OP)
        begin
          out_d = 1'b0;
        end
        wait_d = '0;
        state_d = bsio_pkg::ST_SETTLE;
      end
      bsio_pkg::ST_SETTLE:
      begin
        // Covers the two-stage input synchroniser before the sample is trusted
        wait_d = wait_q + 3'h1;
        if (wait_q == bsio_pkg::SETTLE_CYCLES - 3'h1)
        begin
          strobe_d = 1'b1;
          state_d = bsio_pkg::ST_STROBE;
        end
      end
      bsio_pkg::ST_STROBE:
      begin
        if (op_q == bsio_pkg::STORE_SERIAL_FIELD_OP)
        begin
          acc_d[bitPos[3:0]] = syncB_q;
        end
        if (op_q == bsio_pkg::TEST_BIT_OP)
        begin
          eq_d = syncB_q;
          testDone_d = 1'b1;
        end
        if (idx_q + 5'h01 < len_q)
        begin
          idx_d = idx_q + 5'h01;
          addr_d = addr_q + 15'h0001;
          state_d = bsio_pkg::ST_SETUP;
        end
        else if (op_q == bsio_pkg::STORE_SERIAL_FIELD_OP)
        begin
          state_d = bsio_pkg::ST_PUSH;
        end
        else
        begin
          state_d = bsio_pkg::ST_IDLE;
        end
      end
      bsio_pkg::ST_PUSH:
      begin
        // Stalls here while the receive FIFO is full
        if (pushReady)
        begin
          state_d = bsio_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_d = bsio_pkg::ST_IDLE;
      end
    endcase
    idle_d = (state_d == bsio_pkg::ST_IDLE);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= bsio_pkg::ST_IDLE;
      op_q <= bsio_pkg::TEST_BIT_OP;
      addr_q <= bsio_pkg::ADDR_RESET;
      src_q <= bsio_pkg::WORD_RESET;
      acc_q <= bsio_pkg::WORD_RESET;
      len_q <= '0;
      idx_q <= '0;
      byteMode_q <= 1'b0;
      wait_q <= '0;
      idle_q <= 1'b1;
      strobe_q <= 1'b0;
      out_q <= 1'b0;
      eq_q <= 1'b0;
      testDone_q <= 1'b0;
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      addr_q <= addr_d;
      src_q <= src_d;
      acc_q <= acc_d;
      len_q <= len_d;
      idx_q <= idx_d;
      byteMode_q <= byteMode_d;
      wait_q <= wait_d;
      idle_q <= idle_d;
      strobe_q <= strobe_d;
      out_q <= out_d;
      eq_q <= eq_d;
      testDone_q <= testDone_d;
      syncA_q <= serialInPin;
      syncB_q <= syncA_q;
    end
  end

  // Separate bit space: only bit address, strobe and data pins, no memory strobes
  assign cmdReady = idle_q;
  assign bitAddr = addr_q;
  assign bitStrobe = strobe_q;
  assign serialOutPin = out_q;
  assign equalStatusFlag = eq_q;
  assign testDone = testDone_q;

  bsio_fifo #(
    .WIDTH(bsio_pkg::WORD_W),
    .DEPTH(bsio_pkg::FIFO_DEPTH),
    .PTR_W(bsio_pkg::FIFO_PTR_W)
  ) rxFifo (
    .clock(clock),
    .nrst(nrst),
    .inValid(state_q == bsio_pkg::ST_PUSH),
    .inReady(pushReady),
    .inData(resultWord),
    .outValid(wordValid),
    .outReady(wordReady),
    .outData(wordOut)
  );
endmodule // bsio_unit
`default_nettype wire

// ==== common/bsio_pkg.sv ====
// Shared constants and types for the bit-serial I/O unit
`default_nettype none
package bsio_pkg;
  localparam int ADDR_W = 15;
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_PTR_W = 4;
  localparam logic [ADDR_W-1:0] BIT_SPACE_LAST = 15'h7fff;
  localparam int BASE_LSB = 1;
  localparam int BYTE_LEN_MAX = 8;
  localparam int HIGH_BYTE_LSB = 8;
  localparam logic [CNT_W-1:0] FULL_WORD_LEN = 5'h10;
  localparam logic [2:0] SETTLE_CYCLES = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam int BLOCK_STEP = 32;

  typedef enum logic [2:0] {
    LOAD_SERIAL_FIELD_OP,
    STORE_SERIAL_FIELD_OP,
    TEST_BIT_OP,
    SET_BIT_ONE_OP,
    SET_BIT_ZERO_OP
  } bsio_op_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_SETTLE,
    ST_STROBE,
    ST_PUSH
  } bsio_state_e;
endpackage
`default_nettype wire

// ==== test/bsio_monitor.sv ====
// Port timing checker for the bit-serial I/O unit
`timescale 1ns/100ps
`default_nettype none
module bsio_monitor (
  input wire logic clock,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic [2:0] cmdOp,
  input wire logic [15:0] cmdBase,
  input wire logic [7:0] cmdDisp,
  input wire logic [14:0] bitAddr,
  input wire logic bitStrobe,
  input wire logic serialOutPin,
  input wire logic testDone
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  sequence takeS;
    cmdValid && cmdReady;
  endsequence
  sequence opS(logic [2:0] op);
    cmdValid && cmdReady && cmdOp == op;
  endsequence
  field_base_a: assert property (takeS and cmdOp < 3'h2 |=>
    bitAddr == $past(cmdBase[15:1])) else $error("field base address wrong");
  bit_disp_a: assert property (takeS and cmdOp >= 3'h2 |=> bitAddr ==
    $past(cmdBase[15:1]) + {{7{$past(cmdDisp[7])}}, $past(cmdDisp)})
    else $error("single bit address wrong");
  addr_step_a: assert property (bitStrobe ##1 $changed(bitAddr) |->
    bitAddr == $past(bitAddr) + 15'h1) else $error("address did not step by one");
  strobe_gap_a: assert property (bitStrobe |=> !bitStrobe [*4])
    else $error("bit strobes too close");
  first_strobe_a: assert property (takeS |-> ##5 bitStrobe)
    else $error("first strobe late");
  set_one_a: assert property (opS(3'h3) |-> ##5 bitStrobe && serialOutPin)
    else $error("set one pin wrong");
  set_zero_a: assert property (opS(3'h4) |-> ##5 bitStrobe && !serialOutPin)
    else $error("set zero pin wrong");
  test_done_a: assert property (opS(3'h2) |-> ##6 testDone)
    else $error("test result late");
  busy_hold_a: assert property (takeS |=> !cmdReady [*5])
    else $error("ready during operation");
endmodule // bsio_monitor
bind bsio_unit bsio_monitor bsio_monitor_i (.clock(clock), .nrst(nrst),
  .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdBase(cmdBase),
  .cmdDisp(cmdDisp), .bitAddr(bitAddr), .bitStrobe(bitStrobe),
  .serialOutPin(serialOutPin), .testDone(testDone));
`default_nettype wire

// ==== test/bsio_peer.sv ====
// Model of the bit devices behind the serial pins
`timescale 1ns/100ps
`default_nettype none
module bsio_peer #(
  parameter logic [63:0] IN_BITS = 64'h0
) (
  input wire logic clock,
  input wire logic [14:0] bitAddr,
  input wire logic bitStrobe,
  input wire logic serialOutPin,
  output logic serialInPin
);
  localparam logic [14:0] MID_FLAG_ADDR = 15'h0fed;
  logic [63:0] outBits;
  logic midFlag;
  // Only 64 bits decoded for serialInPin and outBits; higher address lines alias there
  assign serialInPin = IN_BITS[bitAddr[5:0]];
  always @(posedge clock)
  begin
    if (bitStrobe)
    begin
      outBits[bitAddr[5:0]] <= serialOutPin;
    end
    // Full decode on all fifteen lines, so high address bits are exercised
    if (bitStrobe && bitAddr == MID_FLAG_ADDR)
    begin
      midFlag <= serialOutPin;
    end
  end
endmodule // bsio_peer
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench of the bit-serial I/O unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [63:0] IN_BITS = 64'h8000_0000_0000_0246;
  logic clock, nrst, cmdValid, cmdReady, bitStrobe, serialOutPin, serialInPin;
  logic equalStatusFlag, testDone, wordValid, wordReady;
  logic [2:0] cmdOp;
  logic [15:0] cmdBase, cmdWord, wordOut;
  logic [7:0] cmdDisp;
  logic [3:0] cmdCount;
  logic [14:0] bitAddr;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  bsio_unit bsio_unit_i (.clock(clock), .nrst(nrst), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdBase(cmdBase), .cmdDisp(cmdDisp),
    .cmdCount(cmdCount), .cmdWord(cmdWord), .bitAddr(bitAddr), .bitStrobe(bitStrobe),
    .serialOutPin(serialOutPin), .serialInPin(serialInPin),
    .equalStatusFlag(equalStatusFlag), .testDone(testDone), .wordValid(wordValid),
    .wordReady(wordReady), .wordOut(wordOut));
  bsio_peer #(.IN_BITS(IN_BITS)) bsio_peer_i (.clock(clock), .bitAddr(bitAddr),
    .bitStrobe(bitStrobe), .serialOutPin(serialOutPin), .serialInPin(serialInPin));
  task automatic final_report;
  begin
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
  begin
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  end
  endtask
  // Ready is registered, so looking at it mid-cycle avoids an edge race
  task automatic cmd(input logic [2:0] op, input logic [15:0] base, input logic [7:0] disp,
    input logic [3:0] cnt, input logic [15:0] word);
  begin
    @(posedge clock);
    #1;
    cmdOp = op;
    cmdBase = base;
    cmdDisp = disp;
    cmdCount = cnt;
    cmdWord = word;
    cmdValid = 1'b1;
    @(negedge clock);
    while (cmdReady !== 1'b1)
      @(negedge clock);
    @(posedge clock);
    #1 cmdValid = 1'b0;
  end
  endtask
  task automatic idle;
  begin
    @(negedge clock);
    while (cmdReady !== 1'b1)
      @(negedge clock);
  end
  endtask
  task automatic pop(input int n, input logic [15:0] exp);
    int got;
  begin
    got = 0;
    @(posedge clock);
    #1 wordReady = 1'b1;
    while (got < n)
    begin
      @(negedge clock);
      if (wordValid === 1'b1)
      begin
        chk("wordOut", wordOut, exp);
        got++;
      end
    end
    @(posedge clock);
    #1 wordReady = 1'b0;
    @(negedge clock);
    chk("wordValid", {15'h0, wordValid}, 16'h0000);
  end
  endtask
  task automatic t_load;
  begin
    cmd(3'h0, 16'h0020, 8'h00, 4'ha, 16'h0155);
    cmd(3'h0, 16'h0040, 8'h00, 4'h3, 16'h05aa);
    idle;
    chk("outWord", {6'h0, bsio_peer_i.outBits[25:16]}, 16'h0155);
    chk("outByte", {13'h0, bsio_peer_i.outBits[34:32]}, 16'h0005);
  end
  endtask
  task automatic t_set;
  begin
    cmd(3'h3, 16'h0060, 8'hf8, 4'h0, 16'h0000);
    cmd(3'h4, 16'h0060, 8'h01, 4'h0, 16'h0000);
    idle;
    chk("setOne", {15'h0, bsio_peer_i.outBits[40]}, 16'h0001);
    chk("setZero", {15'h0, bsio_peer_i.outBits[49]}, 16'h0000);
  end
  endtask
  task automatic t_test;
  begin
    cmd(3'h2, 16'h0080, 8'hff, 4'h0, 16'h0000);
    idle;
    chk("eqHigh", {15'h0, equalStatusFlag}, {15'h0, IN_BITS[63]});
    cmd(3'h2, 16'h0000, 8'h05, 4'h0, 16'h0000);
    idle;
    chk("eqLow", {15'h0, equalStatusFlag}, {15'h0, IN_BITS[5]});
  end
  endtask
  // Seventeen byte stores with no consumer: the last one must stall
  task automatic t_store;
  begin
    for (int i = 0; i < 17; i++)
      cmd(3'h1, 16'h0004, 8'h00, 4'h2, 16'hffab);
    repeat (40) @(negedge clock);
    chk("cmdReadyFull", {15'h0, cmdReady}, 16'h0000);
    pop(17, {6'h0, IN_BITS[3:2], 8'hab});
    cmd(3'h1, 16'h0000, 8'h00, 4'h0, 16'hffff);
    pop(1, IN_BITS[15:0]);
  end
  endtask
  // Reset in the middle of a set operation, then one command at a high address
  task automatic t_reset;
  begin
    cmd(3'h2, 16'h0080, 8'hff, 4'h0, 16'h0000);
    cmd(3'h3, 16'h0040, 8'h03, 4'h0, 16'h0000);
    chk("eqBeforeReset", {15'h0, equalStatusFlag}, 16'h0001);
    @(posedge clock);
    #1 nrst = 1'b0;
    @(negedge clock);
    chk("rstReady", {15'h0, cmdReady}, 16'h0001);
    chk("rstAddr", {1'h0, bitAddr}, 16'h0000);
    chk("rstStrobe", {15'h0, bitStrobe}, 16'h0000);
    chk("rstOut", {15'h0, serialOutPin}, 16'h0000);
    chk("rstEq", {15'h0, equalStatusFlag}, 16'h0000);
    chk("rstDone", {15'h0, testDone}, 16'h0000);
    chk("rstValid", {15'h0, wordValid}, 16'h0000);
    repeat (2) @(posedge clock);
    #1 nrst = 1'b1;
    cmd(3'h3, 16'h1fda, 8'h00, 4'h0, 16'h0000);
    idle;
    chk("midFlag", {15'h0, bsio_peer_i.midFlag}, 16'h0001);
  end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      error_cnt++;
      final_report;
    end
  end
  initial
  begin
    nrst = 1'b0;
    cmdValid = 1'b0;
    cmdOp = 3'h0;
    cmdBase = 16'h0000;
    cmdDisp = 8'h00;
    cmdCount = 4'h0;
    cmdWord = 16'h0000;
    wordReady = 1'b0;
    repeat (3) @(posedge clock);
    #1 nrst = 1'b1;
    t_load;
    t_set;
    t_test;
    t_store;
    t_reset;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
